// ===== psdp_defines.svh
`ifndef PSDP_DEFINES_SVH
`define PSDP_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PSDP_ADDR_DATA   12'h248
`define PSDP_ADDR_DIR    12'h24C
`define PSDP_ADDR_PIN    12'h250
`define PSDP_ADDR_OWN    12'h254
`define PSDP_DATA_RST    8'h00
`define PSDP_DIR_RST     8'h00
`define PSDP_OE_N_RST    8'hFF
`define PSDP_RD_PAD      24'h000000
`define PSDP_RD_ZERO     32'h00000000

// ----------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------
`define PSDP_BIT_SDA     7
`define PSDP_BIT_MISO    4
`define PSDP_BIT_SCL     4
`define PSDP_BIT_CANTX   3
`define PSDP_BIT_CANRX   2
`define PSDP_BIT_TXD     1
`define PSDP_BIT_RXD     0
`define PSDP_SPI_LINES   4
`define PSDP_SPI_SS      3
`define PSDP_PWM_TXD     7
`define PSDP_PWM_RXD     6
`define PSDP_PWM_SDA     3
`define PSDP_PWM_SCK     2
`define PSDP_BIT_SCK     6
`define PSDP_BIT_MOSI    5
`define PSDP_SPI_SCK     2
`define PSDP_SPI_MOSI    1
`define PSDP_SPI_MISO    0
`define PSDP_PWM_MOSI    1
`define PSDP_PWM_MISO    0

`endif

// ===== psdp_pkg.sv
package psdp_pkg;

	// ------------------------------------------------------------
	// Bus slave states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSDP_ST_IDLE = 2'h1,
		PSDP_ST_ACK  = 2'h2
	} psdp_apb_st_t;

	// ------------------------------------------------------------
	// Peripheral side requests toward the pins
	// ------------------------------------------------------------
	typedef struct packed {
		logic       spi_en;
		logic [3:0] spi_do;
		logic [3:0] spi_doe;
		logic       iic_en;
		logic       iic_sda;
		logic       iic_scl;
		logic [7:0] pwm_en;
		logic [7:0] pwm_do;
		logic       can_en;
		logic       can_tx;
		logic       sci_en;
		logic       sci_txd;
	} psdp_periph_t;

	// ------------------------------------------------------------
	// Pin levels returned to peripherals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] spi_di;
		logic       iic_sda_in;
		logic       iic_scl_in;
		logic       can_receive_pin;
		logic       sci_rxd;
	} psdp_return_t;

	// ------------------------------------------------------------
	// Whole module state
	// ------------------------------------------------------------
	typedef struct packed {
		psdp_apb_st_t st;
		logic [7:0]   data_reg;
		logic [7:0]   dir_reg;
		logic [7:0]   own_reg;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
		logic [7:0]   pin_out;
		logic [7:0]   pin_oe_n;
		psdp_return_t ret;
	} psdp_state_t;

endpackage : psdp_pkg

// ===== psdp_port.sv
// How it works
// [RULE1] Read: output bits give register, inputs give pin
// [RULE2] GPIO output drives stored bit onto pin
// [RULE3] Data register anytime access, clears on reset
// [RULE4] Bit 7: SPI select beats IIC, PWM3, GPIO
// [RULE5] Bit 7: IIC data beats PWM3 and GPIO
// [RULE6] Bit 7: PWM3 beats GPIO
// [RULE7] Bit 6: SPI clock beats PWM2 and GPIO
// [RULE8] Bit 6: PWM2 beats GPIO
// [RULE9] Bit 5: SPI MOSI beats PWM1 and GPIO
// [RULE10] Bit 5: PWM1 beats GPIO
// [RULE11] Bit 4: SPI MISO beats IIC, PWM0, GPIO
// [RULE12] Bit 4: IIC clock beats PWM0 and GPIO
// [RULE13] Bit 4: PWM0 beats GPIO
// [RULE14] Bits 3/2: CAN transmit and receive beat GPIO
// [RULE15] Bit 1: SCI transmit beats PWM7 and GPIO
// [RULE16] Bit 1: PWM7 beats GPIO
// [RULE17] Bit 0: SCI receive beats PWM6 and GPIO
// [RULE18] Bit 0: PWM6 beats GPIO
// [RULE19] Direction 1 is output, 0 is input
// [RULE20] IIC owned pin is open-drain output
// [RULE21] Enabled PWM forces its pin output
// [RULE22] Writes still stored while function owns pin
//
// Local design decision: the APB register port.
`include "psdp_defines.svh"

module psdp_port (
	input  wire logic                  mclk_i,
	input  wire logic                  srst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic [7:0]            pin_in_i,
	output logic      [7:0]            pin_out_o,
	output logic      [7:0]            pin_oe_n_o,
	input  wire psdp_pkg::psdp_periph_t per_i,
	output psdp_pkg::psdp_return_t     ret_o
);

	psdp_pkg::psdp_state_t cur;
	psdp_pkg::psdp_state_t nxt;
	logic [7:0]            own;
	logic [7:0]            aout;
	logic [7:0]            aoen;
	logic [7:0]            rd_data;
	logic                  setup;
	logic                  wr_acc;

	assign setup  = psel_i & ~penable_i;
	assign wr_acc = psel_i & penable_i & cur.pready & pwrite_i;

	// ------------------------------------------------------------
	// Pin ownership and next state
	// ------------------------------------------------------------
	always_comb begin
		int b;
		b    = 0;
		nxt  = cur;
		own  = '0;
		aout = '0;
		aoen = '1;

		// Upper nibble: SPI, then IIC, then PWM channel b-4
		for (int i = 0; i < `PSDP_SPI_LINES; i++) begin
			b = i + `PSDP_BIT_MISO;
			if (per_i.spi_en) begin // RULE4 RULE7 RULE9 RULE11
				own[b]  = 1'b1;
				aout[b] = per_i.spi_do[i];
				aoen[b] = ~per_i.spi_doe[i];
			end else if (per_i.iic_en && b == `PSDP_BIT_SDA) begin // RULE5
				own[b]  = 1'b1;
				aout[b] = 1'b0;
				aoen[b] = per_i.iic_sda; // RULE20
			end else if (per_i.iic_en && b == `PSDP_BIT_SCL) begin // RULE12
				own[b]  = 1'b1;
				aout[b] = 1'b0;
				aoen[b] = per_i.iic_scl; // RULE20
			end else if (per_i.pwm_en[i]) begin // RULE6 RULE8 RULE10 RULE13
				own[b]  = 1'b1;
				aout[b] = per_i.pwm_do[i];
				aoen[b] = 1'b0; // RULE21
			end
		end

		// CAN pair
		if (per_i.can_en) begin // RULE14
			own[`PSDP_BIT_CANTX]  = 1'b1;
			aout[`PSDP_BIT_CANTX] = per_i.can_tx;
			aoen[`PSDP_BIT_CANTX] = 1'b0;
			own[`PSDP_BIT_CANRX]  = 1'b1;
		end

		// SCI transmit, then PWM7
		if (per_i.sci_en) begin // RULE15
			own[`PSDP_BIT_TXD]  = 1'b1;
			aout[`PSDP_BIT_TXD] = per_i.sci_txd;
			aoen[`PSDP_BIT_TXD] = 1'b0;
		end else if (per_i.pwm_en[`PSDP_PWM_TXD]) begin // RULE16
			own[`PSDP_BIT_TXD]  = 1'b1;
			aout[`PSDP_BIT_TXD] = per_i.pwm_do[`PSDP_PWM_TXD];
			aoen[`PSDP_BIT_TXD] = 1'b0; // RULE21
		end

		// SCI receive, then PWM6
		if (per_i.sci_en) begin // RULE17
			own[`PSDP_BIT_RXD] = 1'b1;
		end else if (per_i.pwm_en[`PSDP_PWM_RXD]) begin // RULE18
			own[`PSDP_BIT_RXD]  = 1'b1;
			aout[`PSDP_BIT_RXD] = per_i.pwm_do[`PSDP_PWM_RXD];
			aoen[`PSDP_BIT_RXD] = 1'b0; // RULE21
		end

		// Free pins fall back to general purpose I/O
		for (int i = 0; i < 8; i++) begin
			if (own[i]) begin
				nxt.pin_out[i]  = aout[i];
				nxt.pin_oe_n[i] = aoen[i];
			end else begin
				nxt.pin_out[i]  = cur.data_reg[i]; // RULE2
				nxt.pin_oe_n[i] = ~cur.dir_reg[i]; // RULE19
			end
		end
		nxt.own_reg = own;

		// Pin levels back to the peripherals
		nxt.ret.spi_di          = pin_in_i[7:4];
		nxt.ret.iic_sda_in      = pin_in_i[`PSDP_BIT_SDA];
		nxt.ret.iic_scl_in      = pin_in_i[`PSDP_BIT_SCL];
		nxt.ret.can_receive_pin = pin_in_i[`PSDP_BIT_CANRX];
		nxt.ret.sci_rxd         = pin_in_i[`PSDP_BIT_RXD];

		// Read source follows the direction bit
		rd_data = (cur.dir_reg & cur.data_reg) |
			(~cur.dir_reg & pin_in_i); // RULE1

		// APB slave: one wait-free access phase
		unique case (cur.st)
			psdp_pkg::PSDP_ST_IDLE: begin
				nxt.pready  = 1'b0;
				nxt.pslverr = 1'b0;
				if (setup) begin
					nxt.st      = psdp_pkg::PSDP_ST_ACK;
					nxt.pready  = 1'b1;
					nxt.prdata  = `PSDP_RD_ZERO;
					case (paddr_i)
						`PSDP_ADDR_DATA: begin
							if (!pwrite_i)
								nxt.prdata = {`PSDP_RD_PAD, rd_data};
						end
						`PSDP_ADDR_DIR: begin
							if (!pwrite_i)
								nxt.prdata = {`PSDP_RD_PAD, cur.dir_reg};
						end
						`PSDP_ADDR_PIN: begin
							if (!pwrite_i)
								nxt.prdata = {`PSDP_RD_PAD, pin_in_i};
						end
						`PSDP_ADDR_OWN: begin
							if (!pwrite_i)
								nxt.prdata = {`PSDP_RD_PAD, cur.own_reg};
						end
						default: nxt.pslverr = 1'b1;
					endcase
				end
			end
			psdp_pkg::PSDP_ST_ACK: begin
				if (psel_i && penable_i) begin
					if (wr_acc && paddr_i == `PSDP_ADDR_DATA)
						nxt.data_reg = pwdata_i[7:0]; // RULE3 RULE22
					if (wr_acc && paddr_i == `PSDP_ADDR_DIR)
						nxt.dir_reg = pwdata_i[7:0];
					nxt.st      = psdp_pkg::PSDP_ST_IDLE;
					nxt.pready  = 1'b0;
					nxt.pslverr = 1'b0;
				end
			end
			default: begin
				nxt.st     = psdp_pkg::PSDP_ST_IDLE;
				nxt.pready = 1'b0;
			end
		endcase

		if (srst_i) begin
			nxt          = '0;
			nxt.st       = psdp_pkg::PSDP_ST_IDLE;
			nxt.data_reg = `PSDP_DATA_RST; // RULE3
			nxt.dir_reg  = `PSDP_DIR_RST;
			nxt.pin_oe_n = `PSDP_OE_N_RST;
		end
	end

	always_ff @(posedge mclk_i) begin
		cur <= nxt;
	end

	assign prdata_o   = cur.prdata;
	assign pready_o   = cur.pready;
	assign pslverr_o  = cur.pslverr;
	assign pin_out_o  = cur.pin_out;
	assign pin_oe_n_o = cur.pin_oe_n;
	assign ret_o      = cur.ret;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);

	reset_clears_a: assert property ( // RULE3
		$past(srst_i) |-> cur.data_reg == `PSDP_DATA_RST
	) else $error("data register not cleared by reset");

	read_source_a: assert property ( // RULE1
		cur.st == psdp_pkg::PSDP_ST_IDLE && setup && !pwrite_i &&
		paddr_i == `PSDP_ADDR_DATA |=>
		prdata_o[7:0] == (($past(cur.dir_reg) & $past(cur.data_reg)) |
		(~$past(cur.dir_reg) & $past(pin_in_i))) && pready_o
	) else $error("data read returned wrong source");

	write_store_a: assert property ( // RULE22
		wr_acc && paddr_i == `PSDP_ADDR_DATA |=>
		cur.data_reg == $past(pwdata_i[7:0])
	) else $error("data write not stored");

	answer_once_a: assert property (
		pready_o |=> !pready_o
	) else $error("ready held longer than one cycle");

	generate
		for (genvar g = 0; g < 8; g++) begin : g_chk
			gpio_drive_a: assert property ( // RULE2
				!own[g] && cur.dir_reg[g] |=>
				pin_out_o[g] == $past(cur.data_reg[g]) && !pin_oe_n_o[g]
			) else $error("gpio output not driven");
			gpio_input_a: assert property ( // RULE19
				!own[g] && !cur.dir_reg[g] |=> pin_oe_n_o[g]
			) else $error("gpio input pin driven");
		end
	endgenerate

	spi_first_a: assert property ( // RULE4
		per_i.spi_en |=>
		pin_out_o[`PSDP_BIT_SDA] == $past(per_i.spi_do[`PSDP_SPI_SS])
		&& pin_oe_n_o[`PSDP_BIT_SDA] == !$past(per_i.spi_doe[`PSDP_SPI_SS])
	) else $error("spi select not on bit 7");

	iic_sda_a: assert property ( // RULE5
		!per_i.spi_en && per_i.iic_en |=>
		pin_out_o[`PSDP_BIT_SDA] == 1'b0 &&
		pin_oe_n_o[`PSDP_BIT_SDA] == $past(per_i.iic_sda)
	) else $error("iic data not open drain on bit 7");

	pwm_three_a: assert property ( // RULE6
		!per_i.spi_en && !per_i.iic_en && per_i.pwm_en[`PSDP_PWM_SDA] |=>
		pin_out_o[`PSDP_BIT_SDA] == $past(per_i.pwm_do[`PSDP_PWM_SDA]) &&
		!pin_oe_n_o[`PSDP_BIT_SDA]
	) else $error("pwm3 not on bit 7");

	pwm_two_a: assert property ( // RULE8
		!per_i.spi_en && per_i.pwm_en[`PSDP_PWM_SCK] |=>
		pin_out_o[`PSDP_BIT_SCK] == $past(per_i.pwm_do[`PSDP_PWM_SCK]) &&
		!pin_oe_n_o[`PSDP_BIT_SCK]
	) else $error("pwm2 not on bit 6");

	iic_scl_a: assert property ( // RULE12
		!per_i.spi_en && per_i.iic_en |=>
		!pin_out_o[`PSDP_BIT_SCL] &&
		pin_oe_n_o[`PSDP_BIT_SCL] == $past(per_i.iic_scl)
	) else $error("iic clock not open drain on bit 4");

	can_pins_a: assert property ( // RULE14
		per_i.can_en |=>
		pin_out_o[`PSDP_BIT_CANTX] == $past(per_i.can_tx) &&
		!pin_oe_n_o[`PSDP_BIT_CANTX] && pin_oe_n_o[`PSDP_BIT_CANRX]
	) else $error("can pins not owned");

	sci_txd_a: assert property ( // RULE15
		per_i.sci_en |=>
		pin_out_o[`PSDP_BIT_TXD] == $past(per_i.sci_txd) &&
		!pin_oe_n_o[`PSDP_BIT_TXD] && pin_oe_n_o[`PSDP_BIT_RXD]
	) else $error("sci pins not owned");

	pwm_seven_a: assert property ( // RULE16
		!per_i.sci_en && per_i.pwm_en[`PSDP_PWM_TXD] |=>
		pin_out_o[`PSDP_BIT_TXD] == $past(per_i.pwm_do[`PSDP_PWM_TXD])
	) else $error("pwm7 not on bit 1");

	pwm_six_a: assert property ( // RULE18
		!per_i.sci_en && per_i.pwm_en[`PSDP_PWM_RXD] |=>
		pin_out_o[`PSDP_BIT_RXD] == $past(per_i.pwm_do[`PSDP_PWM_RXD]) &&
		!pin_oe_n_o[`PSDP_BIT_RXD]
	) else $error("pwm6 not on bit 0");

	spi_sck_a: assert property ( // RULE7
		per_i.spi_en |=>
		pin_out_o[`PSDP_BIT_SCK] == $past(per_i.spi_do[`PSDP_SPI_SCK]) &&
		pin_oe_n_o[`PSDP_BIT_SCK] == !$past(per_i.spi_doe[`PSDP_SPI_SCK])
	) else $error("spi clock not on bit 6");

	spi_mosi_a: assert property ( // RULE9
		per_i.spi_en |=>
		pin_out_o[`PSDP_BIT_MOSI] == $past(per_i.spi_do[`PSDP_SPI_MOSI]) &&
		pin_oe_n_o[`PSDP_BIT_MOSI] == !$past(per_i.spi_doe[`PSDP_SPI_MOSI])
	) else $error("spi mosi not on bit 5");

	spi_miso_a: assert property ( // RULE11
		per_i.spi_en |=>
		pin_out_o[`PSDP_BIT_MISO] == $past(per_i.spi_do[`PSDP_SPI_MISO]) &&
		pin_oe_n_o[`PSDP_BIT_MISO] == !$past(per_i.spi_doe[`PSDP_SPI_MISO])
	) else $error("spi miso not on bit 4");

	pwm_one_a: assert property ( // RULE10
		!per_i.spi_en && per_i.pwm_en[`PSDP_PWM_MOSI] |=>
		pin_out_o[`PSDP_BIT_MOSI] == $past(per_i.pwm_do[`PSDP_PWM_MOSI]) &&
		!pin_oe_n_o[`PSDP_BIT_MOSI]
	) else $error("pwm1 not on bit 5");

	pwm_zero_a: assert property ( // RULE13
		!per_i.spi_en && !per_i.iic_en && per_i.pwm_en[`PSDP_PWM_MISO] |=>
		pin_out_o[`PSDP_BIT_MISO] == $past(per_i.pwm_do[`PSDP_PWM_MISO]) &&
		!pin_oe_n_o[`PSDP_BIT_MISO]
	) else $error("pwm0 not on bit 4");

	sci_rxd_a: assert property ( // RULE17
		per_i.sci_en |=>
		pin_oe_n_o[`PSDP_BIT_RXD] &&
		ret_o.sci_rxd == $past(pin_in_i[`PSDP_BIT_RXD])
	) else $error("sci receive pin not an input");

	can_rx_a: assert property ( // RULE14
		per_i.can_en |=>
		ret_o.can_receive_pin == $past(pin_in_i[`PSDP_BIT_CANRX])
	) else $error("can receive level not returned");

	data_hold_a: assert property ( // RULE22
		!(wr_acc && paddr_i == `PSDP_ADDR_DATA) |=> $stable(cur.data_reg)
	) else $error("data register changed without a write");

	dir_hold_a: assert property ( // RULE19
		!(wr_acc && paddr_i == `PSDP_ADDR_DIR) |=> $stable(cur.dir_reg)
	) else $error("direction changed without a write");

	dir_write_a: assert property ( // RULE19
		wr_acc && paddr_i == `PSDP_ADDR_DIR |=>
		cur.dir_reg == $past(pwdata_i[7:0])
	) else $error("direction write not stored");

	dir_read_a: assert property ( // RULE19
		cur.st == psdp_pkg::PSDP_ST_IDLE && setup && !pwrite_i &&
		paddr_i == `PSDP_ADDR_DIR |=>
		prdata_o == {`PSDP_RD_PAD, $past(cur.dir_reg)}
	) else $error("direction read back wrong");

	answer_setup_a: assert property ( // RULE3
		cur.st == psdp_pkg::PSDP_ST_IDLE && setup |=> pready_o
	) else $error("setup not answered in first access cycle");

	mapped_ok_a: assert property ( // RULE3
		cur.st == psdp_pkg::PSDP_ST_IDLE && setup &&
		(paddr_i == `PSDP_ADDR_DATA || paddr_i == `PSDP_ADDR_DIR ||
		paddr_i == `PSDP_ADDR_PIN || paddr_i == `PSDP_ADDR_OWN) |=>
		!pslverr_o
	) else $error("error flagged on a mapped register");

	unmapped_err_a: assert property (
		cur.st == psdp_pkg::PSDP_ST_IDLE && setup &&
		paddr_i != `PSDP_ADDR_DATA && paddr_i != `PSDP_ADDR_DIR &&
		paddr_i != `PSDP_ADDR_PIN && paddr_i != `PSDP_ADDR_OWN |=>
		pslverr_o && prdata_o == `PSDP_RD_ZERO
	) else $error("unmapped access not flagged");

endmodule : psdp_port

// ===== psdp_far.sv
// ----------------------------------------------------------------
// Pin levels seen from outside the port
// ----------------------------------------------------------------
module psdp_far (
	input  wire logic [7:0] pin_out_i,
	input  wire logic [7:0] pin_oe_n_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_in_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Driven pins read back their own level, released pins the outside
	assign pin_in_o = (pin_out_i & ~pin_oe_n_i) | (ext_i & pin_oe_n_i);

endmodule : psdp_far

// ===== tb_port_s_data_and_pin_priority.sv
`include "psdp_defines.svh"

module tb_port_s_data_and_pin_priority;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   mclk_i;
	logic                   srst_i;
	logic                   psel_i;
	logic                   penable_i;
	logic                   pwrite_i;
	logic [11:0]            paddr_i;
	logic [31:0]            pwdata_i;
	logic [31:0]            prdata_o;
	logic                   pready_o;
	logic                   pslverr_o;
	logic [7:0]             pin_in_i;
	logic [7:0]             pin_out_o;
	logic [7:0]             pin_oe_n_o;
	logic [7:0]             ext;
	psdp_pkg::psdp_periph_t per_i;
	psdp_pkg::psdp_periph_t p;
	psdp_pkg::psdp_return_t ret_o;
	logic [31:0]            rd;
	logic                   err;
	int                     err_count;
	int                     compares;
	int                     cyc;

	psdp_port dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
		.per_i(per_i), .ret_o(ret_o)
	);

	psdp_far far (
		.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
		.ext_i(ext), .pin_in_o(pin_in_i)
	);

	// ------------------------------------------------------------
	// Clock, timeout and checking tasks
	// ------------------------------------------------------------
	initial begin
		mclk_i = 1'h0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			summarize();
		end
	end

	task summarize;
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i    <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge mclk_i);
		penable_i <= 1'h1;
		do @(posedge mclk_i); while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'h0;
		penable_i <= 1'h0;
	endtask : apb

	// Apply peripheral requests, check masked pin levels and all enables, unmasked
	task pins(input psdp_pkg::psdp_periph_t v, input logic [7:0] eo,
			input logic [7:0] en, input logic [7:0] m);
		per_i <= v;
		repeat (2) @(posedge mclk_i);
		chk({24'h000000, pin_out_o & m}, {24'h000000, eo & m});
		chk({24'h000000, pin_oe_n_o}, {24'h000000, en});
	endtask : pins

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		srst_i = 1'h1;
		psel_i = 1'h0;
		penable_i = 1'h0;
		pwrite_i = 1'h0;
		paddr_i = 12'h000;
		pwdata_i = 32'h00000000;
		per_i = '0;
		p = '0;
		ext = 8'hC3;
		err_count = 0;
		compares = 0;
		cyc = 0;
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'h0;
		@(posedge mclk_i);
		chk({24'h000000, pin_oe_n_o}, 32'h000000FF);
		apb(1'h1, `PSDP_ADDR_DIR, 32'h000000FF);
		apb(1'h0, `PSDP_ADDR_DATA, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h00000000, err}, 32'h00000000);
		apb(1'h1, `PSDP_ADDR_DATA, 32'hFFFFFFA5);
		apb(1'h0, `PSDP_ADDR_DATA, 32'h00000000);
		chk(rd, 32'h000000A5);
		pins(p, 8'hA5, 8'h00, 8'hFF);
		chk({24'h000000, ret_o}, 32'h000000AB);
		apb(1'h1, `PSDP_ADDR_DIR, 32'h0000000F);
		apb(1'h0, `PSDP_ADDR_DATA, 32'h00000000);
		chk(rd, 32'h000000C5);
		apb(1'h0, `PSDP_ADDR_DIR, 32'h00000000);
		chk(rd, 32'h0000000F);
		apb(1'h1, `PSDP_ADDR_PIN, 32'h000000FF);
		chk({31'h00000000, err}, 32'h00000000);
		apb(1'h0, `PSDP_ADDR_PIN, 32'h00000000);
		chk(rd, 32'h000000C5);
		apb(1'h1, `PSDP_ADDR_DATA, 32'h00000000);
		apb(1'h1, `PSDP_ADDR_DIR, 32'h00000000);
		p.pwm_en = 8'hFF;
		p.pwm_do = 8'hFF;
		pins(p, 8'hF3, 8'h0C, 8'hF3);
		apb(1'h0, `PSDP_ADDR_OWN, 32'h00000000);
		chk(rd, 32'h000000F3);
		p.iic_en = 1'h1;
		p.iic_sda = 1'h1;
		p.iic_scl = 1'h0;
		pins(p, 8'h63, 8'h8C, 8'hF3);
		p.spi_en = 1'h1;
		p.spi_do = 4'hA;
		p.spi_doe = 4'hF;
		pins(p, 8'hA3, 8'h0C, 8'hF3);
		p.can_en = 1'h1;
		p.can_tx = 1'h1;
		pins(p, 8'hAB, 8'h04, 8'hFB);
		p.sci_en = 1'h1;
		p.sci_txd = 1'h0;
		ext <= 8'h3C;
		pins(p, 8'hA8, 8'h05, 8'hFA);
		@(posedge mclk_i);
		chk({24'h000000, ret_o}, 32'h000000AA);
		apb(1'h1, `PSDP_ADDR_DATA, 32'h0000005A);
		apb(1'h1, `PSDP_ADDR_DIR, 32'h000000FF);
		pins('0, 8'h5A, 8'h00, 8'hFF);
		apb(1'h0, 12'h300, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h00000000, err}, 32'h00000001);
		// Reset in mid-run must clear stored data
		srst_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'h0;
		@(posedge mclk_i);
		chk({24'h000000, pin_oe_n_o}, 32'h000000FF);
		apb(1'h1, `PSDP_ADDR_DIR, 32'h000000FF);
		apb(1'h0, `PSDP_ADDR_DATA, 32'h00000000);
		chk(rd, 32'h00000000);
		summarize();
	end

endmodule : tb_port_s_data_and_pin_priority
